// *** src/timer16_mode_clock_compare.v ***
// 16-bit timer core: modes, clock select, capture, counter and compare
// Behaviour
// RULE1: Mode selector from four control bits
// RULE2: Normal mode counts to 0xFFFF, immediate
// RULE3: Phase correct modes, update TOP, overflow BOTTOM
// RULE4: Clear-on-match modes, immediate, overflow MAX
// RULE5: Fast PWM modes, update and overflow TOP
// RULE6: Phase-frequency modes, update and overflow BOTTOM
// RULE7: Filter needs four equal capture samples
// RULE8: Edge select picks falling or rising
// RULE9: Capture copies counter, sets capture flag
// RULE10: No pin capture when capture is TOP
// RULE11: Reserved control bit written zero, reads zero
// RULE12: Clock select stops or divides clock
// RULE13: Selects 6 and 7 use pin edges
// RULE14: Pin counts even when driven as output
// RULE15: Counter byte access through shared temp
// RULE16: Counter write blocks next compare match
// RULE17: Compare A and B checked continuously
// RULE18: Compare writes update both bytes together
// RULE19: Match flag sets one tick later
// RULE20: Capture flag set at TOP instead
// RULE21: Reserved mode falls back to normal
`timescale 1ns/1ps
module timer16_mode_clock_compare
(
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] addr,
  input  wire [7:0] wr_data,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire       capture_input_pin,
  input  wire       ext_count_pin,
  output reg  [7:0] rd_data_q,
  output reg        compare_a_match_q,
  output reg        compare_b_match_q
);
`include "timer16_defs.vh"

  localparam K_NORM = 2'h0;
  localparam K_CTC  = 2'h1;
  localparam K_FAST = 2'h2;
  localparam K_PC   = 2'h3;

  reg  [7:0]  timer_control_a_q;
  reg  [7:0]  timer_control_b_q;
  reg  [15:0] counter_value_q;
  reg  [15:0] counter_value_d;
  reg  [15:0] capture_value_q;
  reg  [15:0] compare_a_buf_q;
  reg  [15:0] compare_b_buf_q;
  reg  [15:0] compare_a_value_q;
  reg  [15:0] compare_b_value_q;
  reg  [7:0]  temp_q;
  reg         count_up_q;
  reg         count_up_d;
  reg         block_q;
  reg         capt_prev_q;
  reg         capture_flag_q;
  reg         compare_a_flag_q;
  reg         compare_b_flag_q;
  reg         overflow_flag_q;
  reg  [7:0]  rd_mux;

  reg  [1:0]  kind;
  reg  [15:0] top;
  reg         capt_is_top;
  reg         upd_at_bottom;
  reg         immediate;

  wire        tick;
  wire        capt_level;
  wire [15:0] wide_wr = {temp_q, wr_data};

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and capture filter

  clock_source_tick u_tick
  (
    .clk              (clk),
    .rst              (rst),
    .clock_source_sel (timer_control_b_q[2:0]),
    .ext_count_pin    (ext_count_pin),
    .tick_q           (tick)
  );

  capture_filter #(.SAMPLES(`FILTER_SAMPLES)) u_filter
  (
    .clk       (clk),
    .rst       (rst),
    .filter_en (timer_control_b_q[`BIT_FILTER_EN]),
    .pin_in    (capture_input_pin),
    .level_q   (capt_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  // RULE1: combine mode bits
  wire [3:0] waveform_mode_sel = {timer_control_b_q[4:3], timer_control_a_q[1:0]};

  always @*
  begin
    kind          = K_NORM;
    top           = `TOP_MAX;
    capt_is_top   = 1'b0;
    upd_at_bottom = 1'b0;
    case (waveform_mode_sel)
      // RULE3: phase correct tops
      4'h1:
      begin
        kind = K_PC;
        top  = `TOP_8BIT;
      end
      4'h2:
      begin
        kind = K_PC;
        top  = `TOP_9BIT;
      end
      4'h3:
      begin
        kind = K_PC;
        top  = `TOP_10BIT;
      end
      // RULE4: clear-on-match tops
      4'h4:
      begin
        kind = K_CTC;
        top  = compare_a_value_q;
      end
      4'hc:
      begin
        kind        = K_CTC;
        top         = capture_value_q;
        capt_is_top = 1'b1;
      end
      // RULE5: fast PWM tops
      4'h5:
      begin
        kind = K_FAST;
        top  = `TOP_8BIT;
      end
      4'h6:
      begin
        kind = K_FAST;
        top  = `TOP_9BIT;
      end
      4'h7:
      begin
        kind = K_FAST;
        top  = `TOP_10BIT;
      end
      4'he:
      begin
        kind        = K_FAST;
        top         = capture_value_q;
        capt_is_top = 1'b1;
      end
      4'hf:
      begin
        kind = K_FAST;
        top  = compare_a_value_q;
      end
      // RULE6: phase-frequency tops (8, 9); 10 and 11 are phase correct
      4'h8:
      begin
        kind          = K_PC;
        top           = capture_value_q;
        capt_is_top   = 1'b1;
        upd_at_bottom = 1'b1;
      end
      4'h9:
      begin
        kind          = K_PC;
        top           = compare_a_value_q;
        upd_at_bottom = 1'b1;
      end
      4'ha:
      begin
        kind        = K_PC;
        top         = capture_value_q;
        capt_is_top = 1'b1;
      end
      4'hb:
      begin
        kind = K_PC;
        top  = compare_a_value_q;
      end
      // RULE2: normal counting
      // RULE21: reserved mode as normal
      default:
      begin
        kind = K_NORM;
        top  = `TOP_MAX;
      end
    endcase
    immediate = (kind == K_NORM) || (kind == K_CTC);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count sequence and events

  wire at_top    = counter_value_q == top;
  wire at_max    = counter_value_q == `TOP_MAX;
  wire at_bottom = counter_value_q == `WORD_RESET;
  wire pc_bottom = (kind == K_PC) && !count_up_q && at_bottom;

  always @*
  begin
    counter_value_d = counter_value_q + 16'h0001;
    count_up_d      = 1'b1;
    case (kind)
      K_CTC:
        if (at_top)
          counter_value_d = `WORD_RESET;
      K_FAST:
        if (counter_value_q >= top)
          counter_value_d = `WORD_RESET;
      K_PC:
      begin
        count_up_d = count_up_q;
        if (count_up_q && counter_value_q >= top)
        begin
          count_up_d      = 1'b0;
          counter_value_d = counter_value_q - 16'h0001;
        end
        else if (!count_up_q && at_bottom)
          count_up_d = 1'b1;
        else if (!count_up_q)
          counter_value_d = counter_value_q - 16'h0001;
      end
      default:
        count_up_d = 1'b1;
    endcase
  end

  // Overflow point per mode
  wire ovf_event = tick && (((kind == K_NORM || kind == K_CTC) && at_max) ||
                            (kind == K_FAST && at_top) || pc_bottom);
  // Buffer update point per mode
  wire upd_event = tick && !immediate && (upd_at_bottom ? pc_bottom : at_top);

  // RULE17: continuous comparison
  // RULE16: blocked after counter write
  wire match_a = tick && !block_q && (counter_value_q == compare_a_value_q);
  wire match_b = tick && !block_q && (counter_value_q == compare_b_value_q);

  // RULE8: edge select
  // RULE10: pin ignored when capture is TOP
  wire capt_edge = !capt_is_top && (timer_control_b_q[`BIT_EDGE_SEL] ?
                   (capt_level && !capt_prev_q) : (!capt_level && capt_prev_q));
  // RULE20: capture flag at TOP
  wire capt_event = capt_edge || (capt_is_top && tick && at_top);

  wire wr_cnt  = wr_en && (addr == `OFS_CNT_LO);
  wire wr_capt = wr_en && (addr == `OFS_CAPT_LO);
  wire wr_cmpa = wr_en && (addr == `OFS_CMPA_LO);
  wire wr_cmpb = wr_en && (addr == `OFS_CMPB_LO);
  wire wr_flag = wr_en && (addr == `OFS_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always @(posedge clk)
  begin
    if (rst)
    begin
      timer_control_a_q <= `CTRL_RESET;
      timer_control_b_q <= `CTRL_RESET;
      counter_value_q   <= `WORD_RESET;
      capture_value_q   <= `WORD_RESET;
      compare_a_buf_q   <= `WORD_RESET;
      compare_b_buf_q   <= `WORD_RESET;
      compare_a_value_q <= `WORD_RESET;
      compare_b_value_q <= `WORD_RESET;
      temp_q            <= 8'h00;
      count_up_q        <= 1'b1;
      block_q           <= 1'b0;
      capt_prev_q       <= 1'b0;
      compare_a_match_q <= 1'b0;
      compare_b_match_q <= 1'b0;
    end
    else
    begin
      capt_prev_q       <= capt_level;
      compare_a_match_q <= match_a;
      compare_b_match_q <= match_b;
      if (wr_en && addr == `OFS_CTRL_A)
        timer_control_a_q <= wr_data & `CTRL_A_RW;
      // RULE11: reserved bit kept zero
      if (wr_en && addr == `OFS_CTRL_B)
        timer_control_b_q <= wr_data & `CTRL_B_RW;
      // RULE15: shared high byte temp
      if (wr_en && (addr == `OFS_CNT_HI || addr == `OFS_CAPT_HI ||
                    addr == `OFS_CMPA_HI || addr == `OFS_CMPB_HI))
        temp_q <= wr_data;
      else if (rd_en && addr == `OFS_CNT_LO)
        temp_q <= counter_value_q[15:8];
      else if (rd_en && addr == `OFS_CAPT_LO)
        temp_q <= capture_value_q[15:8];
      // RULE15: atomic counter write
      if (wr_cnt)
      begin
        counter_value_q <= wide_wr;
        block_q         <= 1'b1;
      end
      else if (tick)
      begin
        counter_value_q <= counter_value_d;
        count_up_q      <= count_up_d;
        block_q         <= 1'b0;
      end
      // RULE9: copy counter on capture
      if (wr_capt)
        capture_value_q <= wide_wr;
      else if (capt_edge)
        capture_value_q <= counter_value_q;
      // RULE18: both bytes at once
      if (wr_cmpa)
        compare_a_buf_q <= wide_wr;
      if (wr_cmpb)
        compare_b_buf_q <= wide_wr;
      // RULE2: immediate or buffered update
      if (immediate && wr_cmpa)
        compare_a_value_q <= wide_wr;
      else if (immediate)
        compare_a_value_q <= compare_a_buf_q;
      else if (upd_event)
        compare_a_value_q <= compare_a_buf_q;
      if (immediate && wr_cmpb)
        compare_b_value_q <= wide_wr;
      else if (immediate)
        compare_b_value_q <= compare_b_buf_q;
      else if (upd_event)
        compare_b_value_q <= compare_b_buf_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, set wins over clear

  always @(posedge clk)
  begin
    if (rst)
    begin
      capture_flag_q   <= 1'b0;
      compare_a_flag_q <= 1'b0;
      compare_b_flag_q <= 1'b0;
      overflow_flag_q  <= 1'b0;
    end
    else
    begin
      // RULE9: capture flag
      capture_flag_q   <= capt_event |
                          (capture_flag_q & ~(wr_flag & wr_data[`BIT_CAPT_FLAG]));
      // RULE19: flag one tick after equality
      compare_a_flag_q <= match_a |
                          (compare_a_flag_q & ~(wr_flag & wr_data[`BIT_CMPA_FLAG]));
      compare_b_flag_q <= match_b |
                          (compare_b_flag_q & ~(wr_flag & wr_data[`BIT_CMPB_FLAG]));
      // RULE3: overflow per mode
      overflow_flag_q  <= ovf_event |
                          (overflow_flag_q & ~(wr_flag & wr_data[`BIT_OVF_FLAG]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, data one cycle after strobe

  always @*
  begin
    case (addr)
      `OFS_CTRL_A:  rd_mux = timer_control_a_q;
      `OFS_CTRL_B:  rd_mux = timer_control_b_q;
      `OFS_CNT_LO:  rd_mux = counter_value_q[7:0];
      `OFS_CAPT_LO: rd_mux = capture_value_q[7:0];
      `OFS_CMPA_LO: rd_mux = compare_a_buf_q[7:0];
      `OFS_CMPA_HI: rd_mux = compare_a_buf_q[15:8];
      `OFS_CMPB_LO: rd_mux = compare_b_buf_q[7:0];
      `OFS_CMPB_HI: rd_mux = compare_b_buf_q[15:8];
      `OFS_CNT_HI:  rd_mux = temp_q;
      `OFS_CAPT_HI: rd_mux = temp_q;
      `OFS_FLAGS:   rd_mux = {2'h0, capture_flag_q, compare_a_flag_q,
                              compare_b_flag_q, overflow_flag_q, 2'h0};
      default:      rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
      rd_data_q <= 8'h00;
    else if (rd_en)
      rd_data_q <= rd_mux;
    else
      rd_data_q <= 8'h00;
  end

endmodule

// *** src/timer16_defs.vh ***
// Register offsets, field positions, reset values and prescale counts
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

`define OFS_CTRL_A    8'h00
`define OFS_CTRL_B    8'h01
`define OFS_CNT_LO    8'h02
`define OFS_CNT_HI    8'h03
`define OFS_CAPT_LO   8'h04
`define OFS_CAPT_HI   8'h05
`define OFS_CMPA_LO   8'h06
`define OFS_CMPA_HI   8'h07
`define OFS_CMPB_LO   8'h08
`define OFS_CMPB_HI   8'h09
`define OFS_FLAGS     8'h0a

`define CTRL_RESET    8'h00
`define WORD_RESET    16'h0000
`define CTRL_A_RW     8'hf3
`define CTRL_B_RW     8'hdf

`define BIT_FILTER_EN 7
`define BIT_EDGE_SEL  6
`define BIT_CAPT_FLAG 5
`define BIT_CMPA_FLAG 4
`define BIT_CMPB_FLAG 3
`define BIT_OVF_FLAG  2

`define TOP_MAX       16'hffff
`define TOP_8BIT      16'h00ff
`define TOP_9BIT      16'h01ff
`define TOP_10BIT     16'h03ff

`define PS_MASK_8     10'h007
`define PS_MASK_64    10'h03f
`define PS_MASK_256   10'h0ff
`define PS_MASK_1024  10'h3ff

`define FILTER_SAMPLES 4

`endif

// *** src/clock_source_tick.v ***
// Clock source selection and prescaler tick generation
`timescale 1ns/1ps
module clock_source_tick
(
  input  wire       clk,
  input  wire       rst,
  input  wire [2:0] clock_source_sel,
  input  wire       ext_count_pin,
  output reg        tick_q
);
`include "timer16_defs.vh"

  reg  [9:0] presc_q;
  reg        ext_prev_q;
  reg        tick_d;

  always @(posedge clk)
  begin
    if (rst)
    begin
      presc_q    <= 10'h000;
      ext_prev_q <= 1'b0;
      tick_q     <= 1'b0;
    end
    else
    begin
      presc_q    <= presc_q + 10'h001;
      ext_prev_q <= ext_count_pin;
      tick_q     <= tick_d;
    end
  end

  always @*
  begin
    case (clock_source_sel)
      // RULE12: stop and divide
      3'h1: tick_d = 1'b1;
      3'h2: tick_d = (presc_q & `PS_MASK_8) == `PS_MASK_8;
      3'h3: tick_d = (presc_q & `PS_MASK_64) == `PS_MASK_64;
      3'h4: tick_d = (presc_q & `PS_MASK_256) == `PS_MASK_256;
      3'h5: tick_d = (presc_q & `PS_MASK_1024) == `PS_MASK_1024;
      // RULE13: external pin edges
      // RULE14: pin sampled regardless of direction
      3'h6: tick_d = ext_prev_q & ~ext_count_pin;
      3'h7: tick_d = ~ext_prev_q & ext_count_pin;
      default: tick_d = 1'b0;
    endcase
  end

endmodule

// *** src/capture_filter.v ***
// Capture input noise filter
`timescale 1ns/1ps
module capture_filter
#(
  parameter SAMPLES = 4
)
(
  input  wire clk,
  input  wire rst,
  input  wire filter_en,
  input  wire pin_in,
  output reg  level_q
);

  reg [SAMPLES-1:0] hist_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      hist_q  <= {SAMPLES{1'b0}};
      level_q <= 1'b0;
    end
    else
    begin
      hist_q <= {hist_q[SAMPLES-2:0], pin_in};
      // RULE7: four equal samples
      if (!filter_en)
        level_q <= pin_in;
      else if (&hist_q)
        level_q <= 1'b1;
      else if (~|hist_q)
        level_q <= 1'b0;
    end
  end

endmodule

// *** testbench/timer16_chk.sv ***
// Checker for the timer register port and match pulses
`timescale 1ns/1ps
module timer16_chk
(
  input wire       clk,
  input wire       rst,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire       wr_en,
  input wire       rd_en,
  input wire       capture_input_pin,
  input wire       ext_count_pin,
  input wire [7:0] rd_data_q,
  input wire       compare_a_match_q,
  input wire       compare_b_match_q
);
  reg [7:0] ctl_a_q;
  reg [7:0] ctl_b_q;
  reg       rd_q;
  reg [7:0] ra_q;

  // Shadow of the control bytes and the last read slot
  always @(posedge clk)
  begin
    rd_q <= rst ? 1'b0 : rd_en;
    ra_q <= addr;
    if (rst)
    begin
      ctl_a_q <= 8'h00;
      ctl_b_q <= 8'h00;
    end
    else if (wr_en && addr == 8'h00)
      ctl_a_q <= wr_data & 8'hf3;
    else if (wr_en && addr == 8'h01)
      ctl_b_q <= wr_data & 8'hdf;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////
  chk_rd_idle: assert property (!$past(rd_en) |-> rd_data_q == 8'h00)
    else $error("read data outside read slot");
  chk_ctl_a_back: assert property (rd_q && ra_q == 8'h00 |-> rd_data_q == ctl_a_q)
    else $error("control a readback wrong");
  chk_ctl_b_back: assert property (rd_q && ra_q == 8'h01 |-> rd_data_q == ctl_b_q)
    else $error("control b readback wrong");
  chk_flags_rsvd: assert property (rd_q && ra_q == 8'h0a |-> (rd_data_q & 8'hc3) == 8'h00)
    else $error("flag reserved bits set");
  chk_unmapped_zero: assert property (rd_q && ra_q > 8'h0a |-> rd_data_q == 8'h00)
    else $error("unmapped read not zero");
  chk_stop_quiet_a: assert property ((ctl_b_q[2:0] == 3'h0) [*3] |-> !compare_a_match_q)
    else $error("match a while stopped");
  chk_stop_quiet_b: assert property ((ctl_b_q[2:0] == 3'h0) [*3] |-> !compare_b_match_q)
    else $error("match b while stopped");
  chk_cnt_wr_block: assert property (wr_en && addr == 8'h02 |-> ##1 !(compare_a_match_q || compare_b_match_q))
    else $error("match after counter write");

  cover property (compare_a_match_q);
  cover property (compare_b_match_q);
  cover property (rd_q && ra_q == 8'h05);
endmodule

// *** testbench/tb_top.sv ***
// Testbench for the 16-bit timer core
`timescale 1ns/1ps
module tb_top;
  reg         clk;
  reg         rst;
  reg  [7:0]  addr;
  reg  [7:0]  wr_data;
  reg         wr_en;
  reg         rd_en;
  reg         cap_pin;
  reg         ext_pin;
  wire [7:0]  rd_data_q;
  wire        match_a;
  wire        match_b;
  integer     n_mismatch;
  integer     n_compared;
  integer     na;
  integer     nb;
  reg  [15:0] v;
  reg  [7:0]  b;

  timer16_mode_clock_compare i_timer16_mode_clock_compare
  (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .capture_input_pin(cap_pin), .ext_count_pin(ext_pin), .rd_data_q(rd_data_q),
    .compare_a_match_q(match_a), .compare_b_match_q(match_b)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  task chk(input string name, input [15:0] e, input [15:0] s);
  begin
    n_compared = n_compared + 1;
    if (s !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", name, e, s);
    end
  end
  endtask

  task wr(input [7:0] a, input [7:0] d);
  begin
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  end
  endtask

  task rd(input [7:0] a, output [7:0] d);
  begin
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rd_data_q;
  end
  endtask

  task wr16(input [7:0] a, input [15:0] d);
  begin
    wr(a + 8'h01, d[15:8]);
    wr(a, d[7:0]);
  end
  endtask

  task rd16(input [7:0] a, output [15:0] d);
    reg [7:0] lo;
    reg [7:0] hi;
  begin
    rd(a, lo);
    rd(a + 8'h01, hi);
    d = {hi, lo};
  end
  endtask

  // Cycles until first pulse on each channel, 0 if none; watching stops at the first A pulse or lim
  task watch(input integer lim);
  begin
    na = 0;
    nb = 0;
    for (int i = 1; i <= lim && na == 0; i++)
    begin
      @(posedge clk);
      if (match_b === 1'b1 && nb == 0)
        nb = i;
      if (match_a === 1'b1)
        na = i;
    end
  end
  endtask

  // Run the counter for k+2 cycles, then stop it
  task run(input [7:0] ctl, input integer k);
  begin
    wr(8'h01, ctl | 8'h01);
    repeat (k) @(posedge clk);
    wr(8'h01, ctl);
  end
  endtask

  task summarize;
  begin
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    cap_pin = 1'b0;
    ext_pin = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 12; a++)
    begin
      rd(a[7:0], b);
      chk("reset_value", 16'h0000, {8'h00, b});
    end
    wr(8'h01, 8'hdf);
    rd(8'h01, b);
    chk("ctrl_b", 16'h00df, {8'h00, b});
    wr(8'h00, 8'hff);
    rd(8'h00, b);
    chk("ctrl_a", 16'h00f3, {8'h00, b});
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h0b, 8'h5a);
    rd(8'h0b, b);
    chk("unmapped", 16'h0000, {8'h00, b});
    wr16(8'h06, 16'h0010);
    wr16(8'h08, 16'h000f);
    rd16(8'h08, v);
    chk("cmp_b", 16'h000f, v);
    wr16(8'h02, 16'h8000);
    repeat (5) @(posedge clk);
    rd16(8'h02, v);
    chk("stopped", 16'h8000, v);
    wr(8'h01, 8'h01);
    wr16(8'h02, 16'h000c);
    watch(20);
    chk("match_a_lag", 16'h0005, na[15:0]);
    chk("match_b_lag", 16'h0004, nb[15:0]);
    wr16(8'h02, 16'h0010);
    watch(20);
    chk("blocked", 16'h0000, na[15:0]);
    wr(8'h01, 8'h08);
    wr16(8'h06, 16'h0005);
    wr16(8'h02, 16'h0000);
    wr(8'h01, 8'h09);
    watch(20);
    watch(20);
    chk("ctc_period", 16'h0006, na[15:0]);
    for (int cs = 6; cs < 8; cs++)
    begin
      wr(8'h01, {5'h00, cs[2:0]});
      wr16(8'h02, 16'h0000);
      repeat (6)
      begin
        ext_pin <= ~ext_pin;
        repeat (3) @(posedge clk);
      end
      rd16(8'h02, v);
      chk("ext_count", 16'h0003, v);
    end
    wr(8'h01, 8'h03);
    wr16(8'h02, 16'h0000);
    repeat (640) @(posedge clk);
    rd16(8'h02, v);
    chk("prescale_64", 16'h0001, {15'h0000, v == 16'h000a || v == 16'h000b});
    wr(8'h01, 8'h40);
    wr16(8'h02, 16'h0abc);
    cap_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h0a, b);
    chk("capt_flag", 16'h0020, {8'h00, b & 8'h20});
    rd16(8'h04, v);
    chk("capt_rise", 16'h0abc, v);
    wr16(8'h02, 16'h0123);
    cap_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rd16(8'h04, v);
    chk("capt_no_fall", 16'h0abc, v);
    wr(8'h01, 8'hc0);
    cap_pin <= 1'b1;
    repeat (2) @(posedge clk);
    cap_pin <= 1'b0;
    repeat (10) @(posedge clk);
    rd16(8'h04, v);
    chk("capt_glitch", 16'h0abc, v);
    wr(8'h01, 8'h80);
    cap_pin <= 1'b1;
    repeat (10) @(posedge clk);
    cap_pin <= 1'b0;
    repeat (10) @(posedge clk);
    rd16(8'h04, v);
    chk("capt_fall", 16'h0123, v);
    wr(8'h01, 8'h58);
    wr16(8'h02, 16'h0777);
    cap_pin <= 1'b1;
    repeat (10) @(posedge clk);
    rd16(8'h04, v);
    chk("capt_as_top", 16'h0123, v);
    rd(8'h0a, b);
    chk("flags_set", 16'h0038, {8'h00, b});
    wr(8'h0a, 8'h3c);
    rd(8'h0a, b);
    chk("flags_clear", 16'h0000, {8'h00, b});
    wr16(8'h02, 16'h0118);
    run(8'h58, 20);
    rd16(8'h02, v);
    chk("capt_top_wrap", 16'h000a, v);
    rd(8'h0a, b);
    chk("capt_top_flag", 16'h0030, {8'h00, b});
    wr(8'h0a, 8'h3c);
    wr16(8'h02, 16'hfff8);
    run(8'h00, 10);
    rd16(8'h02, v);
    chk("normal_wrap", 16'h0004, v);
    rd(8'h0a, b);
    chk("normal_ovf", 16'h0004, {8'h00, b});
    wr(8'h00, 8'h01);
    wr(8'h0a, 8'h3c);
    wr16(8'h02, 16'h00f8);
    run(8'h08, 10);
    rd16(8'h02, v);
    chk("fast_wrap", 16'h0004, v);
    rd(8'h0a, b);
    chk("fast_ovf", 16'h0004, {8'h00, b});
    wr(8'h0a, 8'h3c);
    wr16(8'h02, 16'h00f8);
    run(8'h00, 300);
    rd16(8'h02, v);
    chk("pc_turn", 16'h0028, v);
    rd(8'h0a, b);
    chk("pc_ovf_bottom", 16'h001c, {8'h00, b});
    wr16(8'h02, 16'h03fc);
    run(8'h18, 4);
    rd16(8'h02, v);
    chk("mode13_normal", 16'h0402, v);
    summarize;
  end
endmodule

bind timer16_mode_clock_compare timer16_chk i_timer16_chk
(
  .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .capture_input_pin(capture_input_pin), .ext_count_pin(ext_count_pin), .rd_data_q(rd_data_q),
  .compare_a_match_q(compare_a_match_q), .compare_b_match_q(compare_b_match_q)
);
